/* File: hw/epc_ctrl.sv */
`timescale 1ns/1ns
`include "epc_cfg.svh"
// Summary of operation
// - Strobe low, chip enabled, output disabled.
// - Window restarts at strobe rise, spacing bounded.
// - Chip enable may be the strobe.
// - Lock sequences use page write timing.
module epc_ctrl #(
  parameter int BLC_MAX_CYC = `EPC_BLC_MAX_CYC,
  parameter int WC_CYC = `EPC_WC_CYC,
  parameter int PWRUP_CYC = `EPC_PWRUP_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic [12:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe_out,
  input wire logic [7:0] mem_data_in,
  output logic chip_enable_n_out,
  output logic output_enable_n_out,
  output logic write_strobe_n_out,
  input wire logic ready_busy_n_in
);

  // ---------------------------------------------------------------
  // Constants.
  // ---------------------------------------------------------------
  localparam int CW = 20;
  localparam logic [7:0] WP_END = 8'(`EPC_WP_CYC - 1);
  localparam logic [7:0] GAP_END = 8'(`EPC_BLC_MIN_CYC - 1);
  localparam logic [7:0] ACC_END = 8'(`EPC_ACC_CYC - 1);
  localparam logic [CW-1:0] WIN_END = CW'(BLC_MAX_CYC);
  localparam logic [CW-1:0] WC_END = CW'(WC_CYC - 1);
  localparam logic [CW-1:0] PWR_END = CW'(PWRUP_CYC - 1);

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  epc_pkg::epc_state_t state_r, state_nxt;
  epc_pkg::epc_cmd_t cmd;
  logic [7:0] cnt_r, cnt_nxt;
  logic [CW-1:0] win_r, win_nxt, nvc_r, nvc_nxt, pwr_r, pwr_nxt;
  logic pwr_done_r, pwr_done_nxt;
  logic [12:0] addr_r, addr_nxt, last_addr_r, last_addr_nxt;
  logic [6:0] row_r, row_nxt;
  logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic ce_mode_r, ce_mode_nxt;
  logic loading_r, loading_nxt, polling_r, polling_nxt;
  logic lock_wait_r, lock_wait_nxt, data_loaded_r, data_loaded_nxt;
  logic seq_r, seq_nxt, seq_dis_r, seq_dis_nxt;
  logic [2:0] seq_idx_r, seq_idx_nxt, seq_len_r, seq_len_nxt;
  logic last_bit7_r, last_bit7_nxt, prev6_r, prev6_nxt, first_r, first_nxt;
  logic timeout_r, timeout_nxt, refused_r, refused_nxt, rdy_r;
  logic ack_r, ack_nxt;
  logic [31:0] wbd_r, wbd_nxt;
  logic [12:0] pa_r, pa_nxt;
  logic [7:0] pd_r, pd_nxt;
  logic doe_r, doe_nxt, ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic wr_act, strobe, rd_act, done, nv_busy;

  // Lock sequence table: address and data of step i.
  function automatic logic [20:0] seq_word(input logic dis, input logic [2:0] i);
    logic [20:0] w;
    w = {`EPC_SEQ_ADDR_A, `EPC_SEQ_D1};
    case (i)
      3'h1: w = {`EPC_SEQ_ADDR_B, `EPC_SEQ_D2};
      3'h2: w = {`EPC_SEQ_ADDR_A, dis ? `EPC_SEQ_OFF_PRE : `EPC_SEQ_ON};
      3'h3: w = {`EPC_SEQ_ADDR_A, `EPC_SEQ_D1};
      3'h4: w = {`EPC_SEQ_ADDR_B, `EPC_SEQ_D2};
      3'h5: w = {`EPC_SEQ_ADDR_A, `EPC_SEQ_OFF};
      default: w = {`EPC_SEQ_ADDR_A, `EPC_SEQ_D1};
    endcase
    return w;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd = epc_pkg::CMD_NONE;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    nvc_nxt = nvc_r;
    pwr_nxt = pwr_r;
    pwr_done_nxt = pwr_done_r;
    addr_nxt = addr_r;
    last_addr_nxt = last_addr_r;
    row_nxt = row_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    ce_mode_nxt = ce_mode_r;
    loading_nxt = loading_r;
    polling_nxt = polling_r;
    lock_wait_nxt = lock_wait_r;
    data_loaded_nxt = data_loaded_r;
    seq_nxt = seq_r;
    seq_dis_nxt = seq_dis_r;
    seq_idx_nxt = seq_idx_r;
    seq_len_nxt = seq_len_r;
    last_bit7_nxt = last_bit7_r;
    prev6_nxt = prev6_r;
    first_nxt = first_r;
    timeout_nxt = timeout_r;
    refused_nxt = refused_r;
    pa_nxt = pa_r;
    pd_nxt = pd_r;
    ack_nxt = 1'b0;
    wbd_nxt = wbd_r;
    done = 1'b0;
    nv_busy = polling_r || lock_wait_r || (state_r == epc_pkg::ST_NV_WAIT);
    // Wishbone slave: answer one cycle after the request, unmapped reads zero.
    if (wb_cyc_in && wb_stb_in && !ack_r) begin
      ack_nxt = 1'b1;
      wbd_nxt = 32'h0;
      if (wb_we_in) begin
        case (wb_adr_in)
          `EPC_OFS_CTRL: if (wb_sel_in[0]) cmd = epc_pkg::epc_cmd_t'(wb_dat_in[2:0]);
          `EPC_OFS_ADDR: begin
            if (wb_sel_in[0]) addr_nxt[7:0] = wb_dat_in[7:0];
            if (wb_sel_in[1]) addr_nxt[12:8] = wb_dat_in[12:8];
          end
          `EPC_OFS_WDATA: if (wb_sel_in[0]) wdata_nxt = wb_dat_in[7:0];
          `EPC_OFS_CFG: if (wb_sel_in[0]) ce_mode_nxt = wb_dat_in[`EPC_CFG_CE_MODE_BIT];
          default: wbd_nxt = 32'h0;
        endcase
      end else begin
        case (wb_adr_in)
          `EPC_OFS_ADDR: wbd_nxt = {19'h0, addr_r};
          `EPC_OFS_WDATA: wbd_nxt = {24'h0, wdata_r};
          `EPC_OFS_STATUS: wbd_nxt = {25'h0, refused_r, rdy_r, timeout_r, !pwr_done_r,
                                      nv_busy, loading_r, state_r != epc_pkg::ST_IDLE};
          `EPC_OFS_RDATA: wbd_nxt = {24'h0, rdata_r};
          `EPC_OFS_CFG: wbd_nxt = {31'h0, ce_mode_r};
          default: wbd_nxt = 32'h0;
        endcase
      end
    end
    if (!pwr_done_r) begin
      if (pwr_r == PWR_END) pwr_done_nxt = 1'b1;
      else pwr_nxt = pwr_r + 1'b1;
    end
    if (loading_r && win_r != WIN_END) win_nxt = win_r + 1'b1;
    if (polling_r) nvc_nxt = nvc_r + 1'b1;
    case (state_r)
      epc_pkg::ST_IDLE: begin
        if (cmd != epc_pkg::CMD_NONE) begin
          if (cmd == epc_pkg::CMD_READ && !loading_r) begin
            pa_nxt = addr_r;
            cnt_nxt = 8'h0;
            refused_nxt = 1'b0;
            state_nxt = epc_pkg::ST_RD_ACC;
          end else if (cmd == epc_pkg::CMD_LOAD && pwr_done_r && !nv_busy &&
                       (!loading_r || addr_r[12:`EPC_ROW_LSB] == row_r)) begin
            pa_nxt = addr_r;
            pd_nxt = wdata_r;
            row_nxt = addr_r[12:`EPC_ROW_LSB];
            last_addr_nxt = addr_r;
            last_bit7_nxt = wdata_r[7];
            data_loaded_nxt = 1'b1;
            timeout_nxt = 1'b0;
            refused_nxt = 1'b0;
            state_nxt = epc_pkg::ST_WR_SET;
          end else if ((cmd == epc_pkg::CMD_LOCK_ON || cmd == epc_pkg::CMD_LOCK_OFF) &&
                       pwr_done_r && !nv_busy && !loading_r) begin
            seq_nxt = 1'b1;
            seq_dis_nxt = (cmd == epc_pkg::CMD_LOCK_OFF);
            seq_idx_nxt = 3'h0;
            seq_len_nxt = (cmd == epc_pkg::CMD_LOCK_OFF) ? `EPC_SEQ_LEN_OFF : `EPC_SEQ_LEN_ON;
            {pa_nxt, pd_nxt} = seq_word(cmd == epc_pkg::CMD_LOCK_OFF, 3'h0);
            row_nxt = 7'(`EPC_SEQ_ADDR_A >> `EPC_ROW_LSB);
            lock_wait_nxt = 1'b1;
            data_loaded_nxt = 1'b0;
            timeout_nxt = 1'b0;
            refused_nxt = 1'b0;
            state_nxt = epc_pkg::ST_WR_SET;
          end else begin
            refused_nxt = 1'b1;
          end
        end else if (loading_r && win_r == WIN_END) begin
          loading_nxt = 1'b0;
          nvc_nxt = '0;
          if (lock_wait_r && !data_loaded_r) begin
            state_nxt = epc_pkg::ST_NV_WAIT;
          end else begin
            polling_nxt = 1'b1;
            first_nxt = 1'b1;
            pa_nxt = last_addr_r;
            cnt_nxt = 8'h0;
            state_nxt = epc_pkg::ST_RD_ACC;
          end
        end
      end
      epc_pkg::ST_WR_SET: begin
        cnt_nxt = 8'h0;
        state_nxt = epc_pkg::ST_WR_LOW;
      end
      epc_pkg::ST_WR_LOW: begin
        if (cnt_r == WP_END) state_nxt = epc_pkg::ST_WR_HOLD;
        else cnt_nxt = cnt_r + 1'b1;
      end
      epc_pkg::ST_WR_HOLD: begin
        win_nxt = '0;
        loading_nxt = 1'b1;
        cnt_nxt = 8'h0;
        state_nxt = epc_pkg::ST_WR_GAP;
      end
      epc_pkg::ST_WR_GAP: begin
        if (cnt_r == GAP_END) begin
          if (seq_r && (seq_idx_r + 3'h1) < seq_len_r) begin
            seq_idx_nxt = seq_idx_r + 3'h1;
            {pa_nxt, pd_nxt} = seq_word(seq_dis_r, seq_idx_r + 3'h1);
            state_nxt = epc_pkg::ST_WR_SET;
          end else begin
            seq_nxt = 1'b0;
            state_nxt = epc_pkg::ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      epc_pkg::ST_RD_ACC: begin
        if (cnt_r == ACC_END) begin
          rdata_nxt = mem_data_in;
          state_nxt = epc_pkg::ST_IDLE;
          if (polling_r) begin
            done = !first_r && (prev6_r == mem_data_in[6]) &&
                   (!data_loaded_r || mem_data_in[7] == last_bit7_r);
            prev6_nxt = mem_data_in[6];
            first_nxt = 1'b0;
            if (done) begin
              polling_nxt = 1'b0;
              lock_wait_nxt = 1'b0;
            end else if (nvc_r >= WC_END) begin
              polling_nxt = 1'b0;
              lock_wait_nxt = 1'b0;
              timeout_nxt = 1'b1;
            end else begin
              cnt_nxt = 8'h0;
              state_nxt = epc_pkg::ST_WR_GAP;
              seq_nxt = 1'b0;
            end
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      epc_pkg::ST_NV_WAIT: begin
        if (nvc_r == WC_END) begin
          lock_wait_nxt = 1'b0;
          state_nxt = epc_pkg::ST_IDLE;
        end else begin
          nvc_nxt = nvc_r + 1'b1;
        end
      end
      default: state_nxt = epc_pkg::ST_IDLE;
    endcase
    // A poll read that is not done waits one gap, then reads again.
    if (state_r == epc_pkg::ST_WR_GAP && polling_r && cnt_r == GAP_END) begin
      cnt_nxt = 8'h0;
      state_nxt = epc_pkg::ST_RD_ACC;
    end
    wr_act = (state_nxt == epc_pkg::ST_WR_SET) || (state_nxt == epc_pkg::ST_WR_LOW) ||
             (state_nxt == epc_pkg::ST_WR_HOLD);
    strobe = (state_nxt == epc_pkg::ST_WR_LOW);
    rd_act = (state_nxt == epc_pkg::ST_RD_ACC);
    ce_n_nxt = ce_mode_r ? !(strobe || rd_act) : !(wr_act || rd_act);
    we_n_nxt = ce_mode_r ? !wr_act : !strobe;
    oe_n_nxt = !rd_act;
    doe_nxt = wr_act;
  end

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= epc_pkg::ST_IDLE;
      cnt_r <= 8'h0;
      win_r <= '0;
      nvc_r <= '0;
      pwr_r <= '0;
      pwr_done_r <= 1'b0;
      addr_r <= 13'h0;
      last_addr_r <= 13'h0;
      row_r <= 7'h0;
      wdata_r <= 8'h0;
      rdata_r <= 8'h0;
      ce_mode_r <= `EPC_CFG_RESET;
      loading_r <= 1'b0;
      polling_r <= 1'b0;
      lock_wait_r <= 1'b0;
      data_loaded_r <= 1'b0;
      seq_r <= 1'b0;
      seq_dis_r <= 1'b0;
      seq_idx_r <= 3'h0;
      seq_len_r <= 3'h0;
      last_bit7_r <= 1'b0;
      prev6_r <= 1'b0;
      first_r <= 1'b0;
      timeout_r <= 1'b0;
      refused_r <= 1'b0;
      rdy_r <= 1'b1;
      ack_r <= 1'b0;
      wbd_r <= 32'h0;
      pa_r <= 13'h0;
      pd_r <= 8'h0;
      doe_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      nvc_r <= nvc_nxt;
      pwr_r <= pwr_nxt;
      pwr_done_r <= pwr_done_nxt;
      addr_r <= addr_nxt;
      last_addr_r <= last_addr_nxt;
      row_r <= row_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      ce_mode_r <= ce_mode_nxt;
      loading_r <= loading_nxt;
      polling_r <= polling_nxt;
      lock_wait_r <= lock_wait_nxt;
      data_loaded_r <= data_loaded_nxt;
      seq_r <= seq_nxt;
      seq_dis_r <= seq_dis_nxt;
      seq_idx_r <= seq_idx_nxt;
      seq_len_r <= seq_len_nxt;
      last_bit7_r <= last_bit7_nxt;
      prev6_r <= prev6_nxt;
      first_r <= first_nxt;
      timeout_r <= timeout_nxt;
      refused_r <= refused_nxt;
      rdy_r <= ready_busy_n_in;
      ack_r <= ack_nxt;
      wbd_r <= wbd_nxt;
      pa_r <= pa_nxt;
      pd_r <= pd_nxt;
      doe_r <= doe_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = wbd_r;
  assign mem_addr_out = pa_r;
  assign mem_data_out = pd_r;
  assign mem_data_oe_out = doe_r;
  assign chip_enable_n_out = ce_n_r;
  assign output_enable_n_out = oe_n_r;
  assign write_strobe_n_out = we_n_r;

endmodule

/* File: hw/epc_cfg.svh */
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// ---------------------------------------------------------------
// Register offsets and fields.
// ---------------------------------------------------------------
`define EPC_OFS_CTRL 8'h00
`define EPC_OFS_ADDR 8'h04
`define EPC_OFS_WDATA 8'h08
`define EPC_OFS_STATUS 8'h0c
`define EPC_OFS_RDATA 8'h10
`define EPC_OFS_CFG 8'h14
`define EPC_CMD_LSB 0
`define EPC_CFG_CE_MODE_BIT 0
`define EPC_CFG_RESET 1'b0
`define EPC_ROW_LSB 6

// ---------------------------------------------------------------
// Timing, in nanoseconds, microseconds or milliseconds as each name says, and cycle counts derived from it.
// ---------------------------------------------------------------
`define EPC_CLK_NS 10
`define EPC_WP_NS 100
`define EPC_BLC_MIN_NS 200
`define EPC_ACC_NS 250
`define EPC_BLC_MAX_US 150
`define EPC_WC_MS 5
`define EPC_PWRUP_MS 5
`define EPC_WP_CYC ((`EPC_WP_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_BLC_MIN_CYC ((`EPC_BLC_MIN_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_ACC_CYC ((`EPC_ACC_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_BLC_MAX_CYC ((`EPC_BLC_MAX_US * 1000 + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_WC_CYC ((`EPC_WC_MS * 1000000 + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_PWRUP_CYC ((`EPC_PWRUP_MS * 1000000 + `EPC_CLK_NS - 1) / `EPC_CLK_NS)

// ---------------------------------------------------------------
// Lock command sequences, address and data pairs.
// ---------------------------------------------------------------
`define EPC_SEQ_ADDR_A 13'h1555
`define EPC_SEQ_ADDR_B 13'h0aaa
`define EPC_SEQ_D1 8'haa
`define EPC_SEQ_D2 8'h55
`define EPC_SEQ_ON 8'ha0
`define EPC_SEQ_OFF_PRE 8'h80
`define EPC_SEQ_OFF 8'h20
`define EPC_SEQ_LEN_ON 3'h3
`define EPC_SEQ_LEN_OFF 3'h6

`endif

/* File: hw/epc_pkg.sv */
package epc_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WR_SET = 7'h02,
    ST_WR_LOW = 7'h04,
    ST_WR_HOLD = 7'h08,
    ST_WR_GAP = 7'h10,
    ST_RD_ACC = 7'h20,
    ST_NV_WAIT = 7'h40
  } epc_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_READ = 3'h1,
    CMD_LOAD = 3'h2,
    CMD_LOCK_ON = 3'h3,
    CMD_LOCK_OFF = 3'h4
  } epc_cmd_t;

endpackage

/* File: test/epc_ctrl_asserts.sv */
`timescale 1ns/1ns
module epc_ctrl_asserts #(
  parameter int BLC_MAX_CYC = 200,
  parameter int PWRUP_CYC = 50
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [12:0] mem_addr_out,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe_out,
  input wire logic chip_enable_n_out,
  input wire logic output_enable_n_out,
  input wire logic write_strobe_n_out
);
  // ---------------------------------------------------------------
  // Cycles since the last strobe edges and since reset.
  // ---------------------------------------------------------------
  logic strobe_n;
  logic strobe_r;
  int fall_r, fall_nxt, rise_r, rise_nxt, boot_r, boot_nxt;
  assign strobe_n = write_strobe_n_out | chip_enable_n_out;
  always_comb begin
    fall_nxt = (strobe_r && !strobe_n) ? 1 : fall_r + int'(fall_r < 20);
    rise_nxt = (!strobe_r && strobe_n) ? 1 : rise_r + int'(rise_r < BLC_MAX_CYC);
    boot_nxt = boot_r + int'(boot_r < PWRUP_CYC);
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_r <= 1'b1;
      fall_r <= 20;
      rise_r <= BLC_MAX_CYC;
      boot_r <= 0;
    end else begin
      strobe_r <= strobe_n;
      fall_r <= fall_nxt;
      rise_r <= rise_nxt;
      boot_r <= boot_nxt;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_strobe_low;
    !write_strobe_n_out [*8];
  endsequence
  sequence s_read_low;
    (!output_enable_n_out && !chip_enable_n_out) [*8];
  endsequence
  a_strobe_width: assert property (
    $fell(write_strobe_n_out) |-> s_strobe_low ##[1:8] write_strobe_n_out)
    else $error("write strobe pulse has the wrong width");
  a_no_read_write: assert property (!write_strobe_n_out |-> output_enable_n_out)
    else $error("output enable low while strobing");
  a_no_drive_read: assert property (mem_data_oe_out |-> output_enable_n_out)
    else $error("data driven while output enabled");
  a_addr_held: assert property (
    !write_strobe_n_out && !chip_enable_n_out |-> $stable(mem_addr_out) && $stable(mem_data_out))
    else $error("address or data moved during the strobe");
  a_load_space: assert property ($fell(strobe_n) |-> fall_r >= 20)
    else $error("loads spaced closer than 200 ns");
  a_boot_hold: assert property ($fell(strobe_n) |-> boot_r >= PWRUP_CYC)
    else $error("write strobe during power-up hold");
  a_window_wait: assert property (
    $fell(output_enable_n_out) |-> rise_r >= BLC_MAX_CYC - 1)
    else $error("read began inside the load window");
  a_read_cycle: assert property (
    $fell(output_enable_n_out) |-> write_strobe_n_out ##0 s_read_low)
    else $error("read cycle malformed");
endmodule
bind epc_ctrl epc_ctrl_asserts #(.BLC_MAX_CYC(BLC_MAX_CYC), .PWRUP_CYC(PWRUP_CYC)) u_asserts (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .mem_addr_out(mem_addr_out),
  .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
  .chip_enable_n_out(chip_enable_n_out), .output_enable_n_out(output_enable_n_out),
  .write_strobe_n_out(write_strobe_n_out));

/* File: test/epc_mem_model.sv */
`timescale 1ns/1ns
module epc_mem_model #(
  parameter int BLC_CYC = 190,
  parameter int NV_CYC = 300
) (
  input wire logic clock_in,
  input wire logic [12:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_strobe_n_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic ready_busy_n_out
);
  // ---------------------------------------------------------------
  // Page latch, load window and self-timed write.
  // ---------------------------------------------------------------
  logic [7:0] mem [0:8191];
  logic [7:0] page [0:63];
  logic [63:0] loaded = 64'h0;
  logic [12:0] lat_a = 13'h0;
  logic [6:0] row = 7'h0;
  logic [7:0] last_d = 8'h00;
  logic [47:0] hist = 48'h0;
  logic strobe_q = 1'b1, oe_q = 1'b1, loading = 1'b0, busy = 1'b0, tog = 1'b0;
  int cnt = 0;
  wire strobe_n = write_strobe_n_in | chip_enable_n_in;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign data_oe_out = !chip_enable_n_in && !output_enable_n_in && write_strobe_n_in;
  assign data_out = busy ? {~last_d[7], tog, mem[addr_in][5:0]} : mem[addr_in];
  assign ready_busy_n_out = !busy;
  always @(posedge clock_in) begin
    strobe_q <= strobe_n;
    oe_q <= output_enable_n_in;
    if (busy && output_enable_n_in && !oe_q) tog <= ~tog;
    if (busy) begin
      cnt <= cnt + 1;
      if (cnt == NV_CYC) busy <= 1'b0;
    end else if (output_enable_n_in && strobe_q && !strobe_n) begin
      lat_a <= addr_in;
      cnt <= 0;
    end else if (output_enable_n_in && !strobe_q && strobe_n) begin
      page[lat_a[5:0]] <= data_in;
      loaded[lat_a[5:0]] <= 1'b1;
      row <= lat_a[12:6];
      last_d <= data_in;
      hist <= {hist[39:0], data_in};
      loading <= 1'b1;
      cnt <= 0;
    end else if (loading) begin
      cnt <= cnt + 1;
      if (cnt == BLC_CYC) begin
        for (int i = 0; i < 64; i++) begin
          if (loaded[i]) mem[{row, 6'(i)}] = page[i];
        end
        loaded <= 64'h0;
        loading <= 1'b0;
        busy <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ns
`include "epc_cfg.svh"
module testbench;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0, sel_next = 4'hf;
  logic [7:0] wb_adr = 8'h00, c_dat, m_dat, bus_last = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_q, q;
  logic [12:0] m_addr;
  logic wb_ack, c_oe, m_oe, ce_n, oe_n, we_n, rdy_n;
  wire [7:0] bus_w = c_oe ? c_dat : (m_oe ? m_dat : ~bus_last);
  int bad_count = 0;
  int checked = 0;
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) bus_last <= bus_w;
  epc_ctrl #(.BLC_MAX_CYC(200), .WC_CYC(2000), .PWRUP_CYC(50)) u_epc_ctrl (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
    .wb_ack_out(wb_ack), .wb_dat_out(wb_q), .mem_addr_out(m_addr), .mem_data_out(c_dat),
    .mem_data_oe_out(c_oe), .mem_data_in(bus_w), .chip_enable_n_out(ce_n),
    .output_enable_n_out(oe_n), .write_strobe_n_out(we_n), .ready_busy_n_in(rdy_n));
  epc_mem_model #(.BLC_CYC(190), .NV_CYC(300)) u_epc_mem_model (
    .clock_in(clock_in), .addr_in(m_addr), .data_in(bus_w), .chip_enable_n_in(ce_n),
    .output_enable_n_in(oe_n), .write_strobe_n_in(we_n), .data_out(m_dat),
    .data_oe_out(m_oe), .ready_busy_n_out(rdy_n));
  // ---------------------------------------------------------------
  // Bus tasks.
  // ---------------------------------------------------------------
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= sel_next;
    wb_dat <= d;
    do begin
      @(posedge clock_in);
    end while (wb_ack !== 1'b1);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [12:0] a, input logic [7:0] d, input epc_pkg::epc_cmd_t c);
    xfer(1'b1, `EPC_OFS_ADDR, {19'h0, a});
    xfer(1'b1, `EPC_OFS_WDATA, {24'h0, d});
    xfer(1'b1, `EPC_OFS_CTRL, {29'h0, c});
  endtask
  task automatic wait_st(input logic [31:0] mask);
    int n;
    n = 0;
    repeat (2) @(posedge clock_in);
    do begin
      xfer(1'b0, `EPC_OFS_STATUS, 32'h0);
      n++;
    end while ((q & mask) !== 32'h0 && n < 3000);
    check("status settles", 48'(n < 3000), 48'h1);
  endtask
  task automatic rd(input logic [12:0] a);
    cmd(a, 8'h00, epc_pkg::CMD_READ);
    wait_st(32'h1);
    xfer(1'b0, `EPC_OFS_RDATA, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clock_in);
    $display("watchdog expired");
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    xfer(1'b0, `EPC_OFS_CFG, 32'h0);
    check("cfg reset", q, 48'h0);
    cmd(13'h0045, 8'h11, epc_pkg::CMD_LOAD);
    xfer(1'b0, `EPC_OFS_STATUS, 32'h0);
    check("power-up refusal", q & 32'h48, 48'h48);
    check("no load seen", u_epc_mem_model.hist, 48'h0);
    repeat (60) @(posedge clock_in);
    $display("test power_up done");
    cmd(13'h0045, 8'h3c, epc_pkg::CMD_LOAD);
    wait_st(32'h1);
    cmd(13'h0041, 8'h81, epc_pkg::CMD_LOAD);
    wait_st(32'h1);
    cmd(13'h0000, 8'h00, epc_pkg::CMD_READ);
    xfer(1'b0, `EPC_OFS_STATUS, 32'h0);
    check("read in window", q & 32'h42, 48'h42);
    cmd(13'h0085, 8'h77, epc_pkg::CMD_LOAD);
    xfer(1'b0, `EPC_OFS_STATUS, 32'h0);
    check("foreign row", q[6], 48'h1);
    cmd(13'h0045, 8'hc3, epc_pkg::CMD_LOAD);
    wait_st(32'h7);
    check("column 5", u_epc_mem_model.mem[13'h0045], 48'hc3);
    check("column 1", u_epc_mem_model.mem[13'h0041], 48'h81);
    check("row 2", u_epc_mem_model.mem[13'h0085], 48'hff);
    rd(13'h0045);
    check("read back", q, 48'hc3);
    $display("test page_load done");
    xfer(1'b1, `EPC_OFS_CFG, 32'h1);
    cmd(13'h1f00, 8'h5a, epc_pkg::CMD_LOAD);
    wait_st(32'h7);
    check("ce write", u_epc_mem_model.mem[13'h1f00], 48'h5a);
    rd(13'h1f00);
    check("ce read", q, 48'h5a);
    xfer(1'b1, `EPC_OFS_CFG, 32'h0);
    $display("test ce_mode done");
    cmd(13'h0000, 8'h00, epc_pkg::CMD_LOCK_ON);
    repeat (400) @(posedge clock_in);
    xfer(1'b0, `EPC_OFS_STATUS, 32'h0);
    check("busy pin low", q[5], 48'h0);
    wait_st(32'h7);
    check("busy pin released", q[5], 48'h1);
    check("lock on", u_epc_mem_model.hist[23:0], 48'haa55a0);
    cmd(13'h0000, 8'h00, epc_pkg::CMD_LOCK_OFF);
    wait_st(32'h7);
    check("lock off", u_epc_mem_model.hist, 48'haa5580aa5520);
    $display("test lock done");
    sel_next = 4'h1;
    xfer(1'b1, `EPC_OFS_ADDR, 32'h1fff);
    sel_next = 4'hf;
    xfer(1'b0, `EPC_OFS_ADDR, 32'h0);
    check("addr lane 0 only", q, 48'hff);
    sel_next = 4'h2;
    xfer(1'b1, `EPC_OFS_ADDR, 32'h1e00);
    sel_next = 4'hf;
    xfer(1'b0, `EPC_OFS_ADDR, 32'h0);
    check("addr lane 1 only", q, 48'h1eff);
    xfer(1'b1, 8'h20, 32'hffffffff);
    xfer(1'b0, 8'h20, 32'h0);
    check("unmapped", q, 48'h0);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
